/* common/hspc_pkg.sv */
package hspc_pkg;

    // --------------------------------
    // bus geometry
    // --------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_TRIG = 2;
    localparam int NUM_PINS = 4;

    // --------------------------------
    // register byte offsets
    // --------------------------------
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TOTAL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_INPUT_STATE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SETUP = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PRESET = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_WINDOW_CTRL = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_LOW0 = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_HIGH0 = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_LOW1 = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_HIGH1 = 8'h2C;
    // bounds of output n sit at OFS_LOW0 + n * BOUND_STRIDE
    localparam logic [ADDR_W-1:0] BOUND_STRIDE = 8'h08;

    // --------------------------------
    // field positions
    // --------------------------------
    // input state: pin levels after synchronisation
    localparam int BIT_PIN_A = 0;
    localparam int BIT_PIN_B = 1;
    localparam int BIT_PIN_INDEX = 2;
    localparam int BIT_PIN_LIMIT = 3;
    // setup register
    localparam int BIT_MODE_LO = 0;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_GATE_SEL = 2;
    localparam int BIT_INDEX_EN = 3;
    localparam int BIT_SWITCH_EN = 4;
    localparam int BIT_FROZEN = 5;
    // control register, write only, self clearing
    localparam int BIT_LOAD = 0;
    localparam int BIT_FREEZE_SET = 1;
    localparam int BIT_FREEZE_REL = 2;
    // window control: enables low, live output state from this bit up
    localparam int BIT_WIN_EN = 0;
    localparam int BIT_WIN_STATE = 8;
    localparam int BIT_WIN_ARMED = 16;

    // --------------------------------
    // reset values
    // --------------------------------
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

    // --------------------------------
    // counting modes
    // --------------------------------
    typedef enum logic [1:0] {
        MODE_PULSE_DIR = 2'b00,
        MODE_UP_DOWN = 2'b01,
        MODE_QUAD = 2'b10,
        MODE_NONE = 2'b11
    } hspc_mode_t;

    // --------------------------------
    // timing
    // --------------------------------
    localparam int CLK_KHZ = 200000;
    localparam int GATE_LONG_MS = 1000;
    localparam int GATE_SHORT_MS = 200;
    localparam int GATE_CNT_W = 28;

endpackage : hspc_pkg

/* logic/hspc_step_decoder.sv */
`timescale 1ns/10ps
module hspc_step_decoder
    import hspc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire hspc_pkg::hspc_mode_t counting_mode_select,
    // raw pins: a, b, index, limit switch
    input wire logic [hspc_pkg::NUM_PINS-1:0] pins_raw,
    // synchronised levels and count steps
    output logic [hspc_pkg::NUM_PINS-1:0] pins_level,
    output logic step_up,
    output logic step_down
);

    // --------------------------------
    // synchronisers and history
    // --------------------------------
    logic [NUM_PINS-1:0] meta;
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] prev;
    logic next_up;
    logic next_down;
    logic rise_a;
    logic rise_b;
    logic chg_a;
    logic chg_b;

    // three flops per pin; prev only ever reads the second stage
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta[g] <= 1'b0;
                    level[g] <= 1'b0;
                    prev[g] <= 1'b0;
                end else begin
                    meta[g] <= pins_raw[g];
                    level[g] <= meta[g];
                    prev[g] <= level[g];
                end
            end
        end
    endgenerate

    assign pins_level = level;

    // --------------------------------
    // step decode per mode
    // --------------------------------
    // at 200 MHz a 160 kHz edge train leaves >300 cycles per edge, so
    // one-step-per-cycle decode never drops a count
    always_comb begin
        rise_a = level[BIT_PIN_A] & ~prev[BIT_PIN_A];
        rise_b = level[BIT_PIN_B] & ~prev[BIT_PIN_B];
        chg_a = level[BIT_PIN_A] ^ prev[BIT_PIN_A];
        chg_b = level[BIT_PIN_B] ^ prev[BIT_PIN_B];
        next_up = 1'b0;
        next_down = 1'b0;
        unique case (counting_mode_select)
            MODE_PULSE_DIR: begin
                // a is the pulse, b high counts up
                next_up = rise_a & level[BIT_PIN_B];
                next_down = rise_a & ~level[BIT_PIN_B];
            end
            MODE_UP_DOWN: begin
                // coincident up and down edges cancel
                next_up = rise_a & ~rise_b;
                next_down = rise_b & ~rise_a;
            end
            MODE_QUAD: begin
                // x4 decode; both phases moving at once is a fault, skipped
                if (chg_a ^ chg_b) begin
                    next_up = prev[BIT_PIN_A] ^ level[BIT_PIN_B];
                    next_down = ~(prev[BIT_PIN_A] ^ level[BIT_PIN_B]);
                end
            end
            MODE_NONE: next_up = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            step_up <= 1'b0;
            step_down <= 1'b0;
        end else begin
            step_up <= next_up;
            step_down <= next_down;
        end
    end

endmodule : hspc_step_decoder

/* logic/hspc_counter.sv */
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
// Contract
// - The mode field selects pulse-and-direction at 0, up/down at 1 and quadrature at 2.
// - Pulse rates up to 80 kHz (pulse/dir, up/down) and 160 kHz (quadrature) lose no count.
// - The running 32-bit count is readable by the host at any time.
// - The pulse total is the count at the end of a gate period minus the count at its start.
// - Input A is the pulse, the up pulse or phase one depending on the mode.
// - Input B is the direction, the down pulse or phase two depending on the mode.
// - The status bits of A and B show their present levels, high reading as one.
// - With its enable set a true index input loads the preset; with it clear index does nothing.
// - With its enable set a true limit switch loads the preset; with it clear it is ignored.
// - Two outputs turn on when the count reaches their low bound and off at their high bound.
// - Gate select zero gives a 1 second window and one gives a 200 ms window.
// - Writing one to the load control sets the count to the preset; zero does nothing.
// - Writing one to the freeze control holds the count; zero does nothing.
// - A window output stays off unless both its bounds are written and its enable is set.
module hspc_counter
    import hspc_pkg::*;
#(
    parameter int unsigned GATE_LONG_CYCLES = hspc_pkg::GATE_LONG_MS * hspc_pkg::CLK_KHZ,
    parameter int unsigned GATE_SHORT_CYCLES = hspc_pkg::GATE_SHORT_MS * hspc_pkg::CLK_KHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [hspc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hspc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hspc_pkg::DATA_W-1:0] reg_rdata,
    // encoder pins
    input wire logic pulse_a,
    input wire logic pulse_b,
    input wire logic index_input,
    input wire logic limit_switch_input,
    // window-triggered outputs
    output logic [hspc_pkg::NUM_TRIG-1:0] window_trigger_output
);

    // --------------------------------
    // declarations
    // --------------------------------
    hspc_mode_t counting_mode_select;
    hspc_mode_t next_mode;
    logic gate_period_select;
    logic next_gate_sel;
    logic index_preset_enable;
    logic next_index_en;
    logic switch_preset_enable;
    logic next_switch_en;
    logic freeze_counter;
    logic next_freeze;
    logic [DATA_W-1:0] preset;
    logic [DATA_W-1:0] next_preset;
    logic [NUM_TRIG-1:0] window_enable;
    logic [NUM_TRIG-1:0] next_win_en;
    logic [DATA_W-1:0] window_low_bound [NUM_TRIG];
    logic [DATA_W-1:0] next_low [NUM_TRIG];
    logic [DATA_W-1:0] window_high_bound [NUM_TRIG];
    logic [DATA_W-1:0] next_high [NUM_TRIG];
    logic [NUM_TRIG-1:0] low_written;
    logic [NUM_TRIG-1:0] next_low_written;
    logic [NUM_TRIG-1:0] high_written;
    logic [NUM_TRIG-1:0] next_high_written;

    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] next_count;
    logic [DATA_W-1:0] window_start;
    logic [DATA_W-1:0] next_start;
    logic [DATA_W-1:0] window_pulse_total;
    logic [DATA_W-1:0] next_total;
    logic [GATE_CNT_W-1:0] gate_cnt;
    logic [GATE_CNT_W-1:0] next_gate_cnt;
    logic [GATE_CNT_W-1:0] gate_last;

    logic [NUM_TRIG-1:0] next_trig;
    logic [DATA_W-1:0] next_rdata;

    logic [NUM_PINS-1:0] channel_input_state;
    logic step_up;
    logic step_down;
    logic wr_setup;
    logic wr_control;
    logic preset_load;

    // --------------------------------
    // pin synchronisation and step decode
    // --------------------------------
    hspc_step_decoder u_decoder (
        .clk(clk),
        .rst(rst),
        .counting_mode_select(counting_mode_select),
        .pins_raw({limit_switch_input, index_input, pulse_b, pulse_a}),
        .pins_level(channel_input_state),
        .step_up(step_up),
        .step_down(step_down)
    );

    // --------------------------------
    // configuration registers
    // --------------------------------
    assign wr_setup = reg_wr && (reg_addr == OFS_SETUP);
    assign wr_control = reg_wr && (reg_addr == OFS_CONTROL);

    // next values of everything software writes
    always_comb begin
        next_mode = counting_mode_select;
        next_gate_sel = gate_period_select;
        next_index_en = index_preset_enable;
        next_switch_en = switch_preset_enable;
        next_freeze = freeze_counter;
        next_preset = preset;
        next_win_en = window_enable;
        next_low = window_low_bound;
        next_high = window_high_bound;
        next_low_written = low_written;
        next_high_written = high_written;
        if (wr_setup) begin
            next_mode = hspc_mode_t'(reg_wdata[BIT_MODE_HI:BIT_MODE_LO]);
            next_gate_sel = reg_wdata[BIT_GATE_SEL];
            next_index_en = reg_wdata[BIT_INDEX_EN];
            next_switch_en = reg_wdata[BIT_SWITCH_EN];
        end
        // a zero bit is a no-op; release has its own bit
        if (wr_control && reg_wdata[BIT_FREEZE_SET]) begin
            next_freeze = 1'b1;
        end else if (wr_control && reg_wdata[BIT_FREEZE_REL]) begin
            next_freeze = 1'b0;
        end
        if (reg_wr && (reg_addr == OFS_PRESET)) begin
            next_preset = reg_wdata;
        end
        if (reg_wr && (reg_addr == OFS_WINDOW_CTRL)) begin
            next_win_en = reg_wdata[BIT_WIN_EN +: NUM_TRIG];
        end
        for (int i = 0; i < NUM_TRIG; i++) begin
            if (reg_wr && (reg_addr == OFS_LOW0 + ADDR_W'(i) * BOUND_STRIDE)) begin
                next_low[i] = reg_wdata;
                next_low_written[i] = 1'b1;
            end
            if (reg_wr && (reg_addr == OFS_HIGH0 + ADDR_W'(i) * BOUND_STRIDE)) begin
                next_high[i] = reg_wdata;
                next_high_written[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            counting_mode_select <= MODE_PULSE_DIR;
            gate_period_select <= 1'b0;
            index_preset_enable <= 1'b0;
            switch_preset_enable <= 1'b0;
            freeze_counter <= 1'b0;
            preset <= RST_WORD;
            window_enable <= '0;
            low_written <= '0;
            high_written <= '0;
            for (int i = 0; i < NUM_TRIG; i++) begin
                window_low_bound[i] <= RST_WORD;
                window_high_bound[i] <= RST_WORD;
            end
        end else begin
            counting_mode_select <= next_mode;
            gate_period_select <= next_gate_sel;
            index_preset_enable <= next_index_en;
            switch_preset_enable <= next_switch_en;
            freeze_counter <= next_freeze;
            preset <= next_preset;
            window_enable <= next_win_en;
            low_written <= next_low_written;
            high_written <= next_high_written;
            window_low_bound <= next_low;
            window_high_bound <= next_high;
        end
    end

    // --------------------------------
    // running count and gate window
    // --------------------------------
    // index and limit are levels: while held true the count sits at preset
    assign preset_load = (wr_control && reg_wdata[BIT_LOAD])
        || (index_preset_enable && channel_input_state[BIT_PIN_INDEX])
        || (switch_preset_enable && channel_input_state[BIT_PIN_LIMIT]);

    assign gate_last = gate_period_select ? GATE_CNT_W'(GATE_SHORT_CYCLES - 1)
                                          : GATE_CNT_W'(GATE_LONG_CYCLES - 1);

    // preset beats freeze, so a frozen count can still be reloaded
    always_comb begin
        next_count = count;
        if (preset_load) begin
            next_count = preset;
        end else if (!freeze_counter) begin
            // 32-bit add wraps naturally in both directions
            if (step_up && !step_down) begin
                next_count = count + 32'h0000_0001;
            end else if (step_down && !step_up) begin
                next_count = count - 32'h0000_0001;
            end
        end
        next_gate_cnt = gate_cnt + GATE_CNT_W'(1);
        next_start = window_start;
        next_total = window_pulse_total;
        if (wr_setup) begin
            // new period or mode: restart the window, keep the last total
            next_gate_cnt = '0;
            next_start = count;
        end else if (gate_cnt >= gate_last) begin
            next_gate_cnt = '0;
            next_total = count - window_start;
            next_start = count;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= RST_WORD;
            gate_cnt <= '0;
            window_start <= RST_WORD;
            window_pulse_total <= RST_WORD;
        end else begin
            count <= next_count;
            gate_cnt <= next_gate_cnt;
            window_start <= next_start;
            window_pulse_total <= next_total;
        end
    end

    // --------------------------------
    // window-triggered outputs
    // --------------------------------
    // equality tests mean a preset jump past a bound is not seen
    always_comb begin
        next_trig = window_trigger_output;
        for (int i = 0; i < NUM_TRIG; i++) begin
            if (!(window_enable[i] && low_written[i] && high_written[i])) begin
                next_trig[i] = 1'b0;
            end else if (count == window_high_bound[i]) begin
                next_trig[i] = 1'b0;
            end else if (count == window_low_bound[i]) begin
                next_trig[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            window_trigger_output <= '0;
        end else begin
            window_trigger_output <= next_trig;
        end
    end

    // --------------------------------
    // read port
    // --------------------------------
    // data stands only in the cycle after the read strobe
    always_comb begin
        next_rdata = RST_WORD;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_COUNT: next_rdata = count;
                OFS_TOTAL: next_rdata = window_pulse_total;
                OFS_INPUT_STATE: next_rdata[NUM_PINS-1:0] = channel_input_state;
                OFS_SETUP: begin
                    next_rdata[BIT_MODE_HI:BIT_MODE_LO] = counting_mode_select;
                    next_rdata[BIT_GATE_SEL] = gate_period_select;
                    next_rdata[BIT_INDEX_EN] = index_preset_enable;
                    next_rdata[BIT_SWITCH_EN] = switch_preset_enable;
                    next_rdata[BIT_FROZEN] = freeze_counter;
                end
                OFS_PRESET: next_rdata = preset;
                OFS_WINDOW_CTRL: begin
                    next_rdata[BIT_WIN_EN +: NUM_TRIG] = window_enable;
                    next_rdata[BIT_WIN_STATE +: NUM_TRIG] = window_trigger_output;
                    next_rdata[BIT_WIN_ARMED +: NUM_TRIG] = low_written & high_written;
                end
                OFS_LOW0: next_rdata = window_low_bound[0];
                OFS_HIGH0: next_rdata = window_high_bound[0];
                OFS_LOW1: next_rdata = window_low_bound[1];
                OFS_HIGH1: next_rdata = window_high_bound[1];
                default: next_rdata = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= RST_WORD;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : hspc_counter

/* dv/hspc_counter_assertions.sv */
`timescale 1ns/10ps
module hspc_counter_assertions
    import hspc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [hspc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hspc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [hspc_pkg::DATA_W-1:0] reg_rdata,
    // pins and outputs
    input wire logic pulse_a,
    input wire logic pulse_b,
    input wire logic index_input,
    input wire logic limit_switch_input,
    input wire logic [hspc_pkg::NUM_TRIG-1:0] window_trigger_output
);
    logic [DATA_W-1:0] preset_q;
    logic [4:0] setup_q;
    logic [1:0] en_q;
    logic [1:0] lo_q;
    logic [1:0] hi_q;
    logic [1:0] armed;
    logic rd_cnt;
    logic rd_pins;

    // decodes shared by several checks
    assign armed = en_q & lo_q & hi_q;
    assign rd_cnt = reg_rd && reg_addr == OFS_COUNT;
    assign rd_pins = reg_rd && reg_addr == OFS_INPUT_STATE;

    // shadow of host writes, so no check needs a view inside the block
    always_ff @(posedge clk) begin
        if (rst) begin
            {preset_q, setup_q, en_q, lo_q, hi_q} <= '0;
        end else if (reg_wr) begin
            if (reg_addr == OFS_PRESET) preset_q <= reg_wdata;
            if (reg_addr == OFS_SETUP) setup_q <= reg_wdata[4:0];
            if (reg_addr == OFS_WINDOW_CTRL) en_q <= reg_wdata[1:0];
            if (reg_addr == OFS_LOW0) lo_q[0] <= 1'b1;
            if (reg_addr == OFS_HIGH0) hi_q[0] <= 1'b1;
            if (reg_addr == OFS_LOW1) lo_q[1] <= 1'b1;
            if (reg_addr == OFS_HIGH1) hi_q[1] <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_rdata_idle; !reg_rd |=> reg_rdata == '0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data off a read");
    property p_preset_rb; reg_rd && reg_addr == OFS_PRESET |=> reg_rdata == $past(preset_q);
    endproperty
    a_preset_rb: assert property (p_preset_rb) else $error("preset readback wrong");
    property p_pin_a; $stable(pulse_a)[*5] ##0 rd_pins |=> reg_rdata[0] == $past(pulse_a);
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("level of input a wrong");
    property p_pin_b; $stable(pulse_b)[*5] ##0 rd_pins |=> reg_rdata[1] == $past(pulse_b);
    endproperty
    a_pin_b: assert property (p_pin_b) else $error("level of input b wrong");
    property p_trig_off; 1'b1 |=> (window_trigger_output & ~$past(armed)) == '0; endproperty
    a_trig_off: assert property (p_trig_off) else $error("unarmed output on");
    property p_load;
        ($stable(pulse_a) && $stable(pulse_b))[*3] ##0 reg_wr && reg_addr == OFS_CONTROL
            && reg_wdata[BIT_LOAD] ##1 !reg_wr ##1 rd_cnt |=> reg_rdata == $past(preset_q);
    endproperty
    a_load: assert property (p_load) else $error("immediate load missed");
    property p_index;
        (setup_q[BIT_INDEX_EN] && index_input)[*6] ##0 rd_cnt && $stable(preset_q)
            |=> reg_rdata == $past(preset_q);
    endproperty
    a_index: assert property (p_index) else $error("index load missed");
    property p_limit;
        (setup_q[BIT_SWITCH_EN] && limit_switch_input)[*6] ##0 rd_cnt && $stable(preset_q)
            |=> reg_rdata == $past(preset_q);
    endproperty
    a_limit: assert property (p_limit) else $error("limit load missed");
endmodule : hspc_counter_assertions

bind hspc_counter hspc_counter_assertions hspc_counter_assertions_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_a(pulse_a), .pulse_b(pulse_b),
    .index_input(index_input), .limit_switch_input(limit_switch_input),
    .window_trigger_output(window_trigger_output)
);

/* dv/hspc_enc_model.sv */
`timescale 1ns/10ps
module hspc_enc_model
    import hspc_pkg::*;
(
    // requests from the bench
    input wire logic clk,
    input wire logic go,
    input wire logic up,
    input wire logic [7:0] steps,
    input wire hspc_pkg::hspc_mode_t mode,
    // encoder pins
    output logic pulse_a,
    output logic pulse_b,
    output logic busy
);
    logic [1:0] ph;

    // three cycles per level keeps every edge well clear of the synchroniser
    initial begin
        {pulse_a, pulse_b, busy, ph} = '0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                repeat (steps) begin
                    if (mode == MODE_QUAD) begin
                        ph = up ? ph + 2'h1 : ph - 2'h1;
                        {pulse_a, pulse_b} <= {ph[1], ph[1] ^ ph[0]};
                    end else begin
                        pulse_b <= mode != MODE_UP_DOWN && up;
                        repeat (3) @(posedge clk);
                        if (mode != MODE_UP_DOWN || up) pulse_a <= 1'b1;
                        else pulse_b <= 1'b1;
                        repeat (3) @(posedge clk);
                        pulse_a <= 1'b0;
                        if (mode == MODE_UP_DOWN) pulse_b <= 1'b0;
                    end
                    repeat (3) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : hspc_enc_model

/* dv/testbench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    import hspc_pkg::*;
    localparam int LONG = 200;
    localparam int SHORT = 40;
    logic clk, rst, reg_wr, reg_rd, idx, lim, go, up, pa, pb, busy;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, d, s, p;
    logic [7:0] n;
    logic [1:0] trig;
    hspc_mode_t mode;
    int seed = 14224;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0;
    logic [7:0] ofs [8] = '{OFS_COUNT, OFS_TOTAL, OFS_INPUT_STATE, OFS_SETUP, OFS_PRESET,
        OFS_CONTROL, OFS_WINDOW_CTRL, 8'h30};

    // short gate counts keep the run brief
    hspc_counter #(.GATE_LONG_CYCLES(LONG), .GATE_SHORT_CYCLES(SHORT)) hspc_counter_i (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_a(pa), .pulse_b(pb),
        .index_input(idx), .limit_switch_input(lim), .window_trigger_output(trig));
    hspc_enc_model hspc_enc_model_i (.clk(clk), .go(go), .up(up), .steps(n), .mode(mode),
        .pulse_a(pa), .pulse_b(pb), .busy(busy));

    // clock and cycle count
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
        @(posedge clk);
    endtask : rd

    // steps through the encoder model, then lets the count pipeline settle
    task automatic run(input logic u, input logic [7:0] k);
        int i;
        {go, up, n} <= {1'b1, u, k};
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        for (i = 0; busy !== 1'b0 && i < 3000; i++) @(posedge clk);
        if (i == 3000) error_cnt++;
        if (i == 3000) print_verdict();
        repeat (8) @(posedge clk);
    endtask : run

    function automatic logic [31:0] exp_cnt(int m, logic [31:0] b, logic [7:0] k);
        return (m == 3) ? b : (m == 1) ? b - 32'(k) : b + 32'(k);
    endfunction : exp_cnt

    initial begin
        {rst, reg_wr, reg_rd, idx, lim, go, up} = 7'h40;
        {reg_addr, reg_wdata, n} = '0;
        mode = MODE_PULSE_DIR;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[i]) begin
            rd(ofs[i], d);
            `CHK(d, RST_WORD)
        end
        $display("test reset values done");
        // every mode, with wrap both ways
        for (int m = 0; m < 4; m++) begin
            mode <= hspc_mode_t'(m);
            wr(OFS_SETUP, 32'(m));
            s = (m == 0) ? 32'hFFFF_FFFE : (m == 1) ? 32'h0000_0001 : $random(seed);
            wr(OFS_PRESET, s);
            wr(OFS_CONTROL, 32'h1);
            run(m != 1, 8'(2 + ($random(seed) & 15)));
            rd(OFS_COUNT, d);
            `CHK(d, exp_cnt(m, s, n))
            if (m == 0) rd(OFS_INPUT_STATE, p);
            if (m == 0) `CHK(p[3:0], 4'h2)
            run(m == 1, n);
            rd(OFS_COUNT, d);
            `CHK(d, s)
        end
        $display("test modes done");
        mode <= MODE_PULSE_DIR;
        wr(OFS_SETUP, 32'h0);
        wr(OFS_CONTROL, 32'h2);
        wr(OFS_CONTROL, 32'h0);
        run(1'b1, 8'd5);
        rd(OFS_COUNT, d);
        `CHK(d, s)
        rd(OFS_SETUP, d);
        `CHK(d[BIT_FROZEN], 1'b1)
        wr(OFS_CONTROL, 32'h4);
        run(1'b1, 8'd5);
        rd(OFS_COUNT, d);
        `CHK(d, s + 32'd5)
        $display("test freeze done");
        // index then limit: ignored while disabled, loads once enabled
        for (int j = 0; j < 2; j++) begin
            s = $random(seed);
            wr(OFS_PRESET, s);
            rd(OFS_COUNT, p);
            {lim, idx} <= j ? 2'b10 : 2'b01;
            repeat (6) @(posedge clk);
            rd(OFS_INPUT_STATE, d);
            `CHK(d[3:2], (j ? 2'b10 : 2'b01))
            rd(OFS_COUNT, d);
            `CHK(d, p)
            wr(OFS_SETUP, j ? 32'h10 : 32'h08);
            repeat (6) @(posedge clk);
            rd(OFS_COUNT, d);
            `CHK(d, s)
            {lim, idx} <= 2'b00;
            wr(OFS_SETUP, 32'h0);
        end
        $display("test presets done");
        for (int g = 0; g < 2; g++) begin
            wr(OFS_SETUP, 32'(g) << BIT_GATE_SEL);
            t0 = cyc;
            run(1'b1, g ? 8'd2 : 8'd14);
            while (cyc < t0 + (g ? SHORT : LONG) + 10) @(posedge clk);
            rd(OFS_TOTAL, d);
            `CHK(d, 32'(n))
        end
        $display("test gate done");
        // output 0 window crosses the wrap; output 1 armed but not enabled
        s = 32'hFFFF_FFFD;
        wr(OFS_PRESET, s);
        wr(OFS_CONTROL, 32'h1);
        rd(OFS_COUNT, d);
        `CHK(d, s)
        wr(OFS_LOW0, s + 32'd2);
        wr(OFS_HIGH0, s + 32'd5);
        wr(OFS_LOW1, s + 32'd1);
        wr(OFS_HIGH1, s + 32'd3);
        wr(OFS_WINDOW_CTRL, 32'h1);
        for (int k = 0; k < 7; k++) begin
            `CHK(trig, {1'b0, k >= 2 && k < 5})
            run(1'b1, 8'd1);
        end
        $display("test triggers done");
        print_verdict();
    end
endmodule : testbench
